// file: common/branch_alu_pkg.sv
/*
 * Shared types and constants of the branch, compare and single-register ALU
 * execution unit: operation codes, the issue bundle, flag positions, cycle
 * counts and the small register map.
 * Assumes an external decoder that fetches operands and fills the bundle.
 */
package branch_alu_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int K_W = 12;
    localparam int ADDR_W = 16;
    localparam int REG_ADDR_W = 4;

    // ----------------------------------------------------------------
    // Operations
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP, OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM, OP_INC, OP_DEC, OP_NEG,
        OP_TEST_REG, OP_CLEAR_REG, OP_SET_REG, OP_COMPARE, OP_COMPARE_CARRY,
        OP_COMPARE_IMMEDIATE, OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
        OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT, OP_RELATIVE_JUMP, OP_INDIRECT_JUMP,
        OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_RETURN, OP_INTERRUPT_RETURN
    } op_t;

    // Everything one instruction needs, already fetched by the decoder
    typedef struct packed {
        op_t op;
        logic [DATA_W-1:0] rd_val;
        logic [DATA_W-1:0] rr_val;
        logic [DATA_W-1:0] imm;
        logic [2:0] bit_sel;
        logic io_bit;
        logic [K_W-1:0] k;
        logic [ADDR_W-1:0] z_ptr;
        logic [ADDR_W-1:0] stack_pc;
        logic next_two_words;
    } insn_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } stack_req_t;

    // ----------------------------------------------------------------
    // Status flag positions
    // ----------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ----------------------------------------------------------------
    // Data constants
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] BYTE_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [DATA_W-1:0] MOST_NEG = 8'h80;
    localparam logic [DATA_W-1:0] MOST_POS = 8'h7F;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Program counter steps and cycle counts
    // ----------------------------------------------------------------
    localparam logic [2:0] PC_STEP = 3'h1;
    localparam logic [2:0] SKIP_ONE_WORD = 3'h2;
    localparam logic [2:0] SKIP_TWO_WORDS = 3'h3;
    localparam logic [2:0] REL_BIAS = 3'h1;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_FOUR = 3'h4;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [REG_ADDR_W-1:0] REG_FLAGS = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_PC_LO = 4'h1;
    localparam logic [REG_ADDR_W-1:0] REG_PC_HI = 4'h2;
    localparam logic [REG_ADDR_W-1:0] REG_RESULT = 4'h3;
    localparam logic [REG_ADDR_W-1:0] REG_STATE = 4'h4;

endpackage : branch_alu_pkg

// file: core/branch_alu_core.sv
/*
 * Execution unit for single-register ALU operations, compares, skips,
 * flag branches, jumps, calls and returns of an 8-bit core.
 * Assumes a decoder that presents one instruction bundle per issue while
 * busy is low, and a stack that accepts push and pop pulses.
 */
`timescale 1ns/100ps

module branch_alu_core #(
    parameter int PC_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire branch_alu_pkg::insn_t issue_insn,
    input wire logic [branch_alu_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [branch_alu_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [branch_alu_pkg::DATA_W-1:0] reg_rdata,
    output logic [branch_alu_pkg::DATA_W-1:0] result,
    output logic result_we,
    output logic [branch_alu_pkg::DATA_W-1:0] status_flags,
    output logic [PC_W-1:0] pc,
    output logic busy,
    output branch_alu_pkg::stack_req_t push,
    output logic pop
);

    // ----------------
    // Elaboration checks
    // ----------------
    if (PC_W < branch_alu_pkg::K_W || PC_W > branch_alu_pkg::ADDR_W) begin : g_pc_w_check
        $error("PC_W must lie between the offset width and the address width");
    end

    typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} state_t;
    localparam int D = branch_alu_pkg::DATA_W;

    // ----------------
    // Flag helpers
    // ----------------
    // Logic result: Z and N from the byte, V cleared, S follows N xor V
    function automatic logic [D-1:0] logic_flags(input logic [D-1:0] f, input logic [D-1:0] r);
        logic [D-1:0] o;
        o = f;
        o[branch_alu_pkg::FLAG_Z] = (r == branch_alu_pkg::BYTE_ZERO);
        o[branch_alu_pkg::FLAG_N] = r[D-1];
        o[branch_alu_pkg::FLAG_V] = 1'b0;
        o[branch_alu_pkg::FLAG_S] = r[D-1];
        return o;
    endfunction : logic_flags

    // Subtraction a - b - cin; chain_z keeps Z only if it was already set
    function automatic logic [D-1:0] sub_flags(input logic [D-1:0] f, input logic [D-1:0] a,
                                               input logic [D-1:0] b, input logic cin,
                                               input logic chain_z);
        logic [D-1:0] o;
        logic [D-1:0] r;
        logic z;
        o = f;
        r = a - b - {{(D-1){1'b0}}, cin};
        z = (r == branch_alu_pkg::BYTE_ZERO);
        o[branch_alu_pkg::FLAG_Z] = chain_z ? (z & f[branch_alu_pkg::FLAG_Z]) : z;
        o[branch_alu_pkg::FLAG_N] = r[D-1];
        o[branch_alu_pkg::FLAG_V] = (a[D-1] & ~b[D-1] & ~r[D-1]) | (~a[D-1] & b[D-1] & r[D-1]);
        o[branch_alu_pkg::FLAG_S] = r[D-1] ^ o[branch_alu_pkg::FLAG_V];
        o[branch_alu_pkg::FLAG_C] = (~a[D-1] & b[D-1]) | (b[D-1] & r[D-1]) | (r[D-1] & ~a[D-1]);
        o[branch_alu_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        return o;
    endfunction : sub_flags

    // Increment or decrement: V marks the single signed wrap
    function automatic logic [D-1:0] step_flags(input logic [D-1:0] f, input logic [D-1:0] r,
                                                input logic [D-1:0] wrap);
        logic [D-1:0] o;
        o = logic_flags(f, r);
        o[branch_alu_pkg::FLAG_V] = (r == wrap);
        o[branch_alu_pkg::FLAG_S] = r[D-1] ^ (r == wrap);
        return o;
    endfunction : step_flags

    // ----------------
    // State
    // ----------------
    state_t state_q;
    logic [2:0] wait_q;
    logic [D-1:0] flags_q;
    logic [PC_W-1:0] pc_q;
    logic [D-1:0] result_q;
    logic result_we_q;
    branch_alu_pkg::stack_req_t push_q;
    logic pop_q;
    logic [D-1:0] rdata_q;

    // ----------------
    // Execute: next values for one issued instruction
    // ----------------
    logic take;
    logic [D-1:0] res_d;
    logic we_d;
    logic [D-1:0] flags_d;
    logic [PC_W-1:0] pc_d;
    logic [2:0] cyc_d;
    logic push_d;
    logic pop_d;
    logic [PC_W-1:0] seq_pc;
    logic [PC_W-1:0] rel_pc;
    logic [PC_W-1:0] skip_pc;
    logic [2:0] skip_cyc;
    logic sel_flag;
    logic n_xor_v;
    assign seq_pc = pc_q + PC_W'(branch_alu_pkg::PC_STEP);
    assign rel_pc = pc_q + PC_W'($signed(issue_insn.k)) + PC_W'(branch_alu_pkg::REL_BIAS);
    // Skipping a two-word instruction costs one extra cycle
    assign skip_pc = pc_q + PC_W'(issue_insn.next_two_words ? branch_alu_pkg::SKIP_TWO_WORDS
                                                              : branch_alu_pkg::SKIP_ONE_WORD);
    assign skip_cyc = issue_insn.next_two_words ? branch_alu_pkg::CYC_THREE : branch_alu_pkg::CYC_TWO;
    assign sel_flag = flags_q[issue_insn.bit_sel];
    assign n_xor_v = flags_q[branch_alu_pkg::FLAG_N] ^ flags_q[branch_alu_pkg::FLAG_V];

    always_comb begin
        take = 1'b0;
        res_d = issue_insn.rd_val;
        we_d = 1'b0;
        flags_d = flags_q;
        pc_d = seq_pc;
        cyc_d = branch_alu_pkg::CYC_ONE;
        push_d = 1'b0;
        pop_d = 1'b0;
        unique case (issue_insn.op)
            branch_alu_pkg::OP_SET_BITS_IMM: begin
                res_d = issue_insn.rd_val | issue_insn.imm;
                we_d = 1'b1;
                flags_d = logic_flags(flags_q, res_d);
            end
            branch_alu_pkg::OP_CLEAR_BITS_IMM: begin
                res_d = issue_insn.rd_val & (branch_alu_pkg::BYTE_ONES - issue_insn.imm);
                we_d = 1'b1;
                flags_d = logic_flags(flags_q, res_d);
            end
            branch_alu_pkg::OP_INC: begin
                res_d = issue_insn.rd_val + branch_alu_pkg::BYTE_ONE;
                we_d = 1'b1;
                flags_d = step_flags(flags_q, res_d, branch_alu_pkg::MOST_NEG);
            end
            branch_alu_pkg::OP_DEC: begin
                res_d = issue_insn.rd_val - branch_alu_pkg::BYTE_ONE;
                we_d = 1'b1;
                flags_d = step_flags(flags_q, res_d, branch_alu_pkg::MOST_POS);
            end
            branch_alu_pkg::OP_NEG: begin
                res_d = branch_alu_pkg::BYTE_ZERO - issue_insn.rd_val;
                we_d = 1'b1;
                flags_d = sub_flags(flags_q, branch_alu_pkg::BYTE_ZERO, issue_insn.rd_val, 1'b0, 1'b0);
            end
            branch_alu_pkg::OP_TEST_REG: begin
                res_d = issue_insn.rd_val & issue_insn.rd_val;
                we_d = 1'b1;
                flags_d = logic_flags(flags_q, res_d);
            end
            branch_alu_pkg::OP_CLEAR_REG: begin
                res_d = issue_insn.rd_val ^ issue_insn.rd_val;
                we_d = 1'b1;
                flags_d = logic_flags(flags_q, res_d);
            end
            branch_alu_pkg::OP_SET_REG: begin
                res_d = branch_alu_pkg::BYTE_ONES;
                we_d = 1'b1;
            end
            branch_alu_pkg::OP_COMPARE: begin
                flags_d = sub_flags(flags_q, issue_insn.rd_val, issue_insn.rr_val, 1'b0, 1'b0);
            end
            branch_alu_pkg::OP_COMPARE_CARRY: begin
                flags_d = sub_flags(flags_q, issue_insn.rd_val, issue_insn.rr_val,
                                    flags_q[branch_alu_pkg::FLAG_C], 1'b1);
            end
            branch_alu_pkg::OP_COMPARE_IMMEDIATE: begin
                flags_d = sub_flags(flags_q, issue_insn.rd_val, issue_insn.imm, 1'b0, 1'b0);
            end
            branch_alu_pkg::OP_COMPARE_SKIP_EQUAL: begin
                take = (issue_insn.rd_val == issue_insn.rr_val);
            end
            branch_alu_pkg::OP_SKIP_REG_BIT_CLEAR: begin
                take = ~issue_insn.rr_val[issue_insn.bit_sel];
            end
            branch_alu_pkg::OP_SKIP_REG_BIT_SET: begin
                take = issue_insn.rr_val[issue_insn.bit_sel];
            end
            branch_alu_pkg::OP_SKIP_IO_BIT_CLEAR: begin
                take = ~issue_insn.io_bit;
            end
            branch_alu_pkg::OP_SKIP_IO_BIT_SET: begin
                take = issue_insn.io_bit;
            end
            // Carry, equal, sign and half-carry aliases come in as a flag select
            branch_alu_pkg::OP_BRANCH_FLAG_SET: begin
                take = sel_flag;
            end
            branch_alu_pkg::OP_BRANCH_FLAG_CLEAR: begin
                take = ~sel_flag;
            end
            branch_alu_pkg::OP_BRANCH_SIGNED_GE: begin
                take = ~n_xor_v;
            end
            branch_alu_pkg::OP_BRANCH_SIGNED_LT: begin
                take = n_xor_v;
            end
            branch_alu_pkg::OP_RELATIVE_JUMP: begin
                pc_d = rel_pc;
                cyc_d = branch_alu_pkg::CYC_TWO;
            end
            branch_alu_pkg::OP_INDIRECT_JUMP: begin
                pc_d = issue_insn.z_ptr[PC_W-1:0];
                cyc_d = branch_alu_pkg::CYC_TWO;
            end
            branch_alu_pkg::OP_RELATIVE_CALL: begin
                pc_d = rel_pc;
                push_d = 1'b1;
                cyc_d = branch_alu_pkg::CYC_THREE;
            end
            branch_alu_pkg::OP_INDIRECT_CALL: begin
                pc_d = issue_insn.z_ptr[PC_W-1:0];
                push_d = 1'b1;
                cyc_d = branch_alu_pkg::CYC_THREE;
            end
            branch_alu_pkg::OP_RETURN: begin
                pc_d = issue_insn.stack_pc[PC_W-1:0];
                pop_d = 1'b1;
                cyc_d = branch_alu_pkg::CYC_FOUR;
            end
            branch_alu_pkg::OP_INTERRUPT_RETURN: begin
                pc_d = issue_insn.stack_pc[PC_W-1:0];
                pop_d = 1'b1;
                flags_d[branch_alu_pkg::FLAG_I] = 1'b1;
                cyc_d = branch_alu_pkg::CYC_FOUR;
            end
            default: begin
                take = 1'b0;
            end
        endcase
        // Skips and branches share the taken path; untaken costs one cycle
        if (take) begin
            if (issue_insn.op inside {branch_alu_pkg::OP_BRANCH_FLAG_SET, branch_alu_pkg::OP_BRANCH_FLAG_CLEAR,
                                      branch_alu_pkg::OP_BRANCH_SIGNED_GE, branch_alu_pkg::OP_BRANCH_SIGNED_LT}) begin
                pc_d = rel_pc;
                cyc_d = branch_alu_pkg::CYC_TWO;
            end else begin
                pc_d = skip_pc;
                cyc_d = skip_cyc;
            end
        end
    end
    logic accept;
    assign accept = issue_valid && (state_q == ST_IDLE);

    // ----------------
    // Sequencer: holds busy for the extra cycles of an instruction
    // ----------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            wait_q <= 3'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept && cyc_d != branch_alu_pkg::CYC_ONE) begin
                        state_q <= ST_WAIT;
                        wait_q <= cyc_d - branch_alu_pkg::CYC_TWO;
                    end
                end
                ST_WAIT: begin
                    if (wait_q == 3'h0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        wait_q <= wait_q - 3'h1;
                    end
                end
            endcase
        end
    end

    // ----------------
    // Status flags: an executing instruction beats a software write
    // ----------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= branch_alu_pkg::FLAGS_RESET;
        end else if (accept) begin
            flags_q <= flags_d;
        end else if (reg_wr && reg_addr == branch_alu_pkg::REG_FLAGS) begin
            flags_q <= reg_wdata;
        end
    end

    // ----------------
    // Program counter, result and stack strobes
    // ----------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= '0;
        end else if (accept) begin
            pc_q <= pc_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= branch_alu_pkg::BYTE_ZERO;
            result_we_q <= 1'b0;
        end else begin
            result_we_q <= accept && we_d;
            if (accept && we_d) begin
                result_q <= res_d;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_q <= '0;
            pop_q <= 1'b0;
        end else begin
            // Return address is the word after the call
            push_q.valid <= accept && push_d;
            push_q.addr <= branch_alu_pkg::ADDR_W'(seq_pc);
            pop_q <= accept && pop_d;
        end
    end

    // ----------------
    // Register read port, data one cycle after the strobe
    // ----------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= branch_alu_pkg::BYTE_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                branch_alu_pkg::REG_FLAGS: rdata_q <= flags_q;
                branch_alu_pkg::REG_PC_LO: rdata_q <= pc_q[D-1:0];
                branch_alu_pkg::REG_PC_HI: rdata_q <= D'(branch_alu_pkg::ADDR_W'(pc_q) >> D);
                branch_alu_pkg::REG_RESULT: rdata_q <= result_q;
                branch_alu_pkg::REG_STATE: rdata_q <= {{(D-1){1'b0}}, state_q == ST_WAIT};
                default: rdata_q <= branch_alu_pkg::BYTE_ZERO;
            endcase
        end else begin
            rdata_q <= branch_alu_pkg::BYTE_ZERO;
        end
    end

    // ----------------
    // Outputs
    // ----------------
    logic busy_q;
    // Registered from the next state so it is not a cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            busy_q <= accept && cyc_d != branch_alu_pkg::CYC_ONE;
        end else begin
            busy_q <= wait_q != 3'h0;
        end
    end

    assign reg_rdata = rdata_q;
    assign result = result_q;
    assign result_we = result_we_q;
    assign status_flags = flags_q;
    assign pc = pc_q;
    assign busy = busy_q;
    assign push = push_q;
    assign pop = pop_q;

endmodule : branch_alu_core

// file: verification/branch_alu_properties.sv
/* Port checker for branch_alu_core.
   Assumes no issue is made while an instruction is still running. */
`timescale 1ns/100ps
module branch_alu_properties #(
    parameter int PC_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire branch_alu_pkg::insn_t issue_insn,
    input wire logic [7:0] result,
    input wire logic result_we,
    input wire logic [7:0] status_flags,
    input wire logic [PC_W-1:0] pc,
    input wire logic busy,
    input wire branch_alu_pkg::stack_req_t push,
    input wire logic pop
);
    wire idle = issue_valid && !busy;
    branch_alu_pkg::op_t op;
    assign op = issue_insn.op;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----
    // Busy tails, counted from the cycle after issue
    // ----
    sequence tail2; busy ##1 !busy; endsequence
    sequence tail3; busy [*2] ##1 !busy; endsequence
    sequence tail4; busy [*3] ##1 !busy; endsequence
    AST_SET_BITS: assert property (idle && op == branch_alu_pkg::OP_SET_BITS_IMM |=> result_we
        && result == ($past(issue_insn.rd_val) | $past(issue_insn.imm))) else $error("set bits wrong");
    AST_CLEAR_BITS: assert property (idle && op == branch_alu_pkg::OP_CLEAR_BITS_IMM |=>
        result == ($past(issue_insn.rd_val) & (8'hFF - $past(issue_insn.imm)))) else $error("clear bits wrong");
    AST_SET_REG: assert property (idle && op == branch_alu_pkg::OP_SET_REG |=>
        result == 8'hFF && $stable(status_flags)) else $error("set register wrong");
    AST_COMPARE: assert property (idle && (op == branch_alu_pkg::OP_COMPARE
        || op == branch_alu_pkg::OP_COMPARE_IMMEDIATE) |=> !result_we && $stable(result)) else $error("compare wrote");
    AST_UNTAKEN: assert property (idle && op == branch_alu_pkg::OP_BRANCH_FLAG_SET
        && !status_flags[issue_insn.bit_sel] |=> pc == $past(pc) + 1'b1 && !busy) else $error("untaken branch");
    AST_REL_JUMP: assert property (idle && op == branch_alu_pkg::OP_RELATIVE_JUMP |=>
        pc == $past(pc) + $past(issue_insn.k) + 1'b1 ##0 tail2) else $error("relative jump wrong");
    AST_SIGNED_LT: assert property (idle && op == branch_alu_pkg::OP_BRANCH_SIGNED_LT
        && (status_flags[2] ^ status_flags[3]) |=> pc == $past(pc) + $past(issue_insn.k) + 1'b1 ##0 tail2)
        else $error("signed less branch wrong");
    AST_CALL: assert property (idle && op == branch_alu_pkg::OP_RELATIVE_CALL |=> push.valid
        && push.addr == 16'($past(pc)) + 1'b1 ##0 tail3) else $error("call push wrong");
    AST_RETURN: assert property (idle && op == branch_alu_pkg::OP_RETURN |=> pop
        && pc == PC_W'($past(issue_insn.stack_pc)) ##0 tail4) else $error("return wrong");
endmodule : branch_alu_properties

// file: verification/tb_top.sv
/* Directed bench for branch_alu_core, driving its ports itself.
   Assumes the package constants; no decoder or stack model in front. */
`timescale 1ns/100ps
module tb_top;
    localparam int PC_W = 12;
    logic clk = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, result, status_flags;
    branch_alu_pkg::insn_t issue_insn = '0, i = '0;
    logic result_we, busy, pop;
    logic [PC_W-1:0] pc, epc = '0;
    branch_alu_pkg::stack_req_t push;
    int miscompares = 0, checks = 0;
    always #4 clk = ~clk;
    branch_alu_core #(.PC_W(PC_W)) DUT (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
        .issue_insn(issue_insn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result(result), .result_we(result_we),
        .status_flags(status_flags), .pc(pc), .busy(busy), .push(push), .pop(pop));
    // ----
    // Drivers
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Spare cycle so outputs have settled
    task automatic iss(input branch_alu_pkg::op_t op, input int n);
        i.op = op;
        issue_valid <= 1'b1;
        issue_insn <= i;
        @(posedge clk);
        issue_valid <= 1'b0;
        epc = epc + 1'b1;
        repeat (n) @(posedge clk);
    endtask : iss
    task automatic jmp(input branch_alu_pkg::op_t op, input int n, input logic [PC_W-1:0] target);
        iss(op, n);
        epc = target;
        chk(pc, epc);
    endtask : jmp
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(reg_rdata, e);
    endtask : rd
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // ----
    // Scenarios
    // ----
    task automatic t_alu;
        rd(branch_alu_pkg::REG_FLAGS, 8'h00);
        rd(4'hF, 8'h00);
        wr(branch_alu_pkg::REG_FLAGS, 8'hA5);
        rd(branch_alu_pkg::REG_FLAGS, 8'hA5);
        wr(branch_alu_pkg::REG_FLAGS, 8'h00);
        i.rd_val = 8'hA5;
        i.imm = 8'h0A;
        iss(branch_alu_pkg::OP_SET_BITS_IMM, 1);
        chk(status_flags, 8'h14);
        i.rd_val = 8'h0F;
        i.imm = 8'h0F;
        iss(branch_alu_pkg::OP_CLEAR_BITS_IMM, 1);
        chk(status_flags, 8'h02);
        iss(branch_alu_pkg::OP_SET_REG, 1);
        chk(status_flags, 8'h02);
        i.rd_val = 8'h7F;
        iss(branch_alu_pkg::OP_INC, 1);
        chk({result, status_flags}, 16'h800C);
        i.rd_val = 8'h01;
        iss(branch_alu_pkg::OP_NEG, 1);
        chk({result, status_flags}, 16'hFF35);
        i.rd_val = 8'h33;
        i.imm = 8'h33;
        iss(branch_alu_pkg::OP_COMPARE_IMMEDIATE, 1);
        chk(status_flags, 8'h02);
        i.rd_val = 8'h05;
        i.rr_val = 8'h07;
        iss(branch_alu_pkg::OP_COMPARE, 1);
        chk({result, status_flags}, 16'hFF35);
        chk(pc, epc);
        $display("alu test done");
    endtask : t_alu
    task automatic t_branch;
        i.k = 12'hFFD;
        for (int b = 0; b < 8; b++) begin
            wr(branch_alu_pkg::REG_FLAGS, 8'h01 << b);
            i.bit_sel = b[2:0];
            jmp(branch_alu_pkg::OP_BRANCH_FLAG_SET, 2, epc + i.k + 1'b1);
            jmp(branch_alu_pkg::OP_BRANCH_FLAG_CLEAR, 1, epc + 1'b1);
        end
        wr(branch_alu_pkg::REG_FLAGS, 8'h00);
        jmp(branch_alu_pkg::OP_BRANCH_FLAG_CLEAR, 2, epc + i.k + 1'b1);
        jmp(branch_alu_pkg::OP_BRANCH_FLAG_SET, 1, epc + 1'b1);
        wr(branch_alu_pkg::REG_FLAGS, 8'h04);
        jmp(branch_alu_pkg::OP_BRANCH_SIGNED_GE, 1, epc + 1'b1);
        jmp(branch_alu_pkg::OP_BRANCH_SIGNED_LT, 2, epc + i.k + 1'b1);
        wr(branch_alu_pkg::REG_FLAGS, 8'h0C);
        jmp(branch_alu_pkg::OP_BRANCH_SIGNED_GE, 2, epc + i.k + 1'b1);
        jmp(branch_alu_pkg::OP_BRANCH_SIGNED_LT, 1, epc + 1'b1);
        $display("branch test done");
    endtask : t_branch
    task automatic t_flow;
        i.rd_val = 8'h10;
        i.rr_val = 8'h10;
        i.bit_sel = 3'h4;
        i.next_two_words = 1'b1;
        jmp(branch_alu_pkg::OP_COMPARE_SKIP_EQUAL, 3, epc + 2'h3);
        i.next_two_words = 1'b0;
        jmp(branch_alu_pkg::OP_SKIP_REG_BIT_SET, 2, epc + 2'h2);
        jmp(branch_alu_pkg::OP_SKIP_REG_BIT_CLEAR, 1, epc + 1'b1);
        i.io_bit = 1'b0;
        jmp(branch_alu_pkg::OP_SKIP_IO_BIT_CLEAR, 2, epc + 2'h2);
        jmp(branch_alu_pkg::OP_SKIP_IO_BIT_SET, 1, epc + 1'b1);
        i.rr_val = 8'h11;
        jmp(branch_alu_pkg::OP_COMPARE_SKIP_EQUAL, 1, epc + 1'b1);
        chk(status_flags, 8'h0C);
        i.k = 12'h7F0;
        i.z_ptr = 16'h0123;
        i.stack_pc = 16'h0456;
        jmp(branch_alu_pkg::OP_RELATIVE_JUMP, 2, epc + i.k + 1'b1);
        jmp(branch_alu_pkg::OP_INDIRECT_JUMP, 2, 12'h123);
        jmp(branch_alu_pkg::OP_RELATIVE_CALL, 3, epc + i.k + 1'b1);
        jmp(branch_alu_pkg::OP_INDIRECT_CALL, 3, 12'h123);
        jmp(branch_alu_pkg::OP_RETURN, 4, 12'h456);
        jmp(branch_alu_pkg::OP_INTERRUPT_RETURN, 4, 12'h456);
        rd(branch_alu_pkg::REG_PC_LO, 8'h56);
        rd(branch_alu_pkg::REG_PC_HI, 8'h04);
        $display("flow test done");
    endtask : t_flow
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_alu();
        t_branch();
        t_flow();
        complete_run();
    end
    // Run needs under a thousand cycles
    initial begin
        #40000;
        miscompares++;
        complete_run();
    end
endmodule : tb_top
bind branch_alu_core branch_alu_properties #(.PC_W(PC_W)) props (.clk(clk), .rst_n(rst_n),
    .issue_valid(issue_valid), .issue_insn(issue_insn), .result(result), .result_we(result_we),
    .status_flags(status_flags), .pc(pc), .busy(busy), .push(push), .pop(pop));
